// File: rtl/ctrl_port_defs.svh
// Constants for the dual mode control port slave.
// Assumes inclusion by bare name from the package; the module uses its macros without an include.
`ifndef CTRL_PORT_DEFS_SVH
`define CTRL_PORT_DEFS_SVH
`define TW_ADDR_FIXED 5'h0D
`define FW_ADDR_FIXED 6'h00
`define SUB_MAX 12'hFFF
`define SUB_PAD 4'h0
`define LATCH_PULSES 2'h3
`define BYTE_BITS 4'h8
`define DATA_BYTE_IDX 2'h3
`endif

// File: rtl/ctrl_port_pkg.sv
// Types shared by the control port slave.
// Assumes the defs header sits on the include path.
package ctrl_port_pkg;
  `include "ctrl_port_defs.svh"
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic write;
  } mem_req_t;
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_SUBH, TW_SUBL, TW_WDATA, TW_RDATA, TW_MACK
  } tw_state_t;
  typedef enum logic [1:0] {
    FW_ADDR, FW_SUB, FW_DATA, FW_SKIP
  } fw_state_t;
endpackage

// File: rtl/dual_mode_control_port_slave.sv
// Slave control port: two-wire and four-wire access to the core memory.
// Assumes a core memory port on mclk answering reads within one cycle
// and a word length lookup table supplied by the integrator.
//
// Function
// - Two-wire side only responds as slave, never starts a transfer.
// - Address fixed bits 01101, low two address bits from select pins.
// - First byte ranges 0x68 to 0x6F by pins and direction.
// - First byte LSB gives direction, one read, zero write.
// - Burst subaddress advances after each word of one to eight bytes.
// - Start is SDA fall, stop SDA rise, with SCL high.
// - Shift eight address bits MSB first, ack on ninth if matched.
// - Acknowledge written bytes on their ninth clock, except invalid-subaddress or past-top ones.
// - Device drives read bytes, host acks, nack ends read.
// - Stop out of sequence returns the device to idle; start out of sequence restarts at the address byte.
// - Invalid subaddress gets no acknowledge; the next written byte gets none and returns to idle.
// - Burst read past top keeps returning highest location contents.
// - Burst write past top drops byte, no ack, back to idle.
// - Start two-wire, switch to four-wire after three latch lows.
// - Four-wire mode holds until full reset.
// - Four-wire input sampled on rising serial clock edges.
// - Output changes on falling edges, host samples on rising.
// - Output line released except while a read is running.
// - Chip byte, two subaddress bytes, data from fourth byte.
// - Subaddress is twelve bits, upper four bits zero padded.
// - Four-wire chip address 0000000 or 0000001 by select pin.
// - Four-wire read drives output from start of fourth byte.
`timescale 1ns/1ps
module dual_mode_control_port_slave
  import ctrl_port_pkg::*;
#(
  parameter logic [11:0] SUB_TOP = `SUB_MAX,
  parameter logic [11:0] SUB_INVALID_LO = 12'hFFF,
  // Three bits per 256-word block: word length minus one
  parameter logic [47:0] LEN_TABLE = 48'h0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic serial_port_clock,
  input wire logic serial_input_line,
  input wire logic transaction_latch,
  output logic serial_output_line,
  output logic serial_output_oe_n,
  input wire logic addr_select_lo_pin,
  input wire logic addr_select_hi_pin,
  output mem_req_t mem_req,
  output logic mem_req_valid,
  input wire logic [7:0] mem_rdata,
  output logic four_wire_mode
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] scl_s, sda_s, lat_s, alo_s, ahi_s;
  logic scl_d, sda_d, lat_d;
  always_ff @(posedge mclk) begin
    scl_s <= {scl_s[0], scl_in};
    sda_s <= {sda_s[0], sda_in};
    lat_s <= {lat_s[0], transaction_latch};
    alo_s <= {alo_s[0], addr_select_lo_pin};
    ahi_s <= {ahi_s[0], addr_select_hi_pin};
    scl_d <= scl_s[1];
    sda_d <= sda_s[1];
    lat_d <= lat_s[1];
  end
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;
  wire lat_fall = lat_d & ~lat_s[1];

  // ------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------
  logic [1:0] lat_cnt;
  wire next_fw = four_wire_mode | (lat_fall & lat_cnt == `LATCH_PULSES - 2'h1);
  always_ff @(posedge mclk) begin
    if (rst) begin
      lat_cnt <= 2'h0;
      four_wire_mode <= 1'b0;
    end else begin
      if (lat_fall && !four_wire_mode)
        lat_cnt <= lat_cnt + 2'h1;
      four_wire_mode <= next_fw;
    end
  end

  // Word length lookup, one less than bytes per word
  function automatic logic [2:0] word_len(input logic [11:0] a);
    word_len = LEN_TABLE[{1'b0, a[11:8], 1'b0} + {2'h0, a[11:8]} +: 3];
  endfunction

  // ------------------------------------------------------------
  // Two-wire engine
  // ------------------------------------------------------------
  tw_state_t tw;
  logic [7:0] sh;
  logic [3:0] bitn;
  logic ack_phase, tw_rd, drive_low, drv_bit;
  logic [11:0] sub;
  logic [2:0] bcnt;
  logic tw_req;
  // Set once a burst write has used the top location
  logic past_top;
  wire [7:0] my_addr = {`TW_ADDR_FIXED, ahi_s[1], alo_s[1], 1'b0};
  wire addr_hit = sh[7:1] == my_addr[7:1];
  wire [11:0] sub_full = {sub[11:8], sh};
  wire sub_bad = sub >= SUB_INVALID_LO && SUB_INVALID_LO != 12'hFFF;
  wire at_top = sub == SUB_TOP;
  wire word_end = bcnt == word_len(sub);
  wire [7:0] sh_next = {sh[6:0], sda};
  always_ff @(posedge mclk) begin
    if (rst || four_wire_mode) begin
      tw <= TW_IDLE;
      bitn <= 4'h0;
      ack_phase <= 1'b0;
      drive_low <= 1'b0;
      drv_bit <= 1'b1;
      tw_rd <= 1'b0;
      sh <= 8'h00;
      sub <= 12'h000;
      bcnt <= 3'h0;
      tw_req <= 1'b0;
      past_top <= 1'b0;
    end else begin
      tw_req <= 1'b0;
      if (start_c) begin
        tw <= TW_ADDR;
        past_top <= 1'b0;
        bitn <= 4'h0;
        ack_phase <= 1'b0;
        drive_low <= 1'b0;
        drv_bit <= 1'b1;
      end else if (stop_c) begin
        tw <= TW_IDLE;
        drive_low <= 1'b0;
        drv_bit <= 1'b1;
      end else if (tw != TW_IDLE && scl_rise && !ack_phase) begin
        sh <= sh_next;
        bitn <= bitn + 4'h1;
      end else if (tw != TW_IDLE && scl_rise && ack_phase && tw == TW_MACK) begin
        // Advance early so the core read settles before the ninth fall
        if (sda)
          tw <= TW_IDLE;
        else begin
          bcnt <= word_end ? 3'h0 : bcnt + 3'h1;
          if (word_end && !at_top)
            sub <= sub + 12'h001;
        end
      end else if (tw != TW_IDLE && scl_fall) begin
        if (!ack_phase && bitn == `BYTE_BITS) begin
          ack_phase <= 1'b1;
          bitn <= 4'h0;
          drv_bit <= 1'b1;
          unique case (tw)
            TW_ADDR: begin
              if (addr_hit) begin
                drive_low <= 1'b1;
                tw_rd <= sh[0];
              end else
                tw <= TW_IDLE;
            end
            TW_SUBH: begin
              sub[11:8] <= sh[3:0];
              drive_low <= sh[7:4] == `SUB_PAD;
              if (sh[7:4] != `SUB_PAD)
                tw <= TW_IDLE;
            end
            TW_SUBL: begin
              sub <= sub_full;
              drive_low <= !(sub_full >= SUB_INVALID_LO &&
                             SUB_INVALID_LO != 12'hFFF);
              bcnt <= 3'h0;
            end
            TW_WDATA: begin
              if (sub_bad || past_top) begin
                drive_low <= 1'b0;
                tw <= TW_IDLE;
              end else begin
                drive_low <= 1'b1;
                tw_req <= 1'b1;
              end
            end
            TW_RDATA: begin
              drive_low <= 1'b0;
              tw <= TW_MACK;
            end
            default: tw <= TW_IDLE;
          endcase
        end else if (ack_phase) begin
          ack_phase <= 1'b0;
          drive_low <= 1'b0;
          unique case (tw)
            TW_ADDR: tw <= tw_rd ? TW_RDATA : TW_SUBH;
            TW_SUBH: tw <= TW_SUBL;
            TW_SUBL: tw <= TW_WDATA;
            TW_WDATA: begin
              bcnt <= word_end ? 3'h0 : bcnt + 3'h1;
              if (word_end && at_top)
                past_top <= 1'b1;
              else if (word_end)
                sub <= sub + 12'h001;
            end
            TW_MACK: tw <= TW_RDATA;
            default: tw <= TW_IDLE;
          endcase
          if (tw == TW_ADDR && tw_rd || tw == TW_MACK) begin
            sh <= mem_rdata;
            drv_bit <= mem_rdata[7];
          end
        end else if (tw == TW_RDATA) begin
          drv_bit <= sh[7];
        end
      end
    end
  end
  // Slave only: the clock line is never driven, SDA only pulled low
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= !(drive_low || (tw == TW_RDATA && !drv_bit));
    end
  end

  // ------------------------------------------------------------
  // Four-wire engine on the serial clock
  // ------------------------------------------------------------
  fw_state_t fw;
  logic [7:0] fsh;
  logic [2:0] fbit;
  logic fw_rd, fw_dir_ok;
  logic [11:0] fsub;
  logic [2:0] fbcnt;
  logic [7:0] fdata;
  logic fw_tog;
  logic [11:0] fwaddr;
  logic [1:0] fw_alo_s;
  // Pin level retimed into the link domain before the address compare
  always_ff @(posedge serial_port_clock) begin
    fw_alo_s <= {fw_alo_s[0], addr_select_lo_pin};
  end
  wire fw_in_frame = ~transaction_latch;
  wire [7:0] fsh_next = {fsh[6:0], serial_input_line};
  wire fw_wr_byte = fw_in_frame && fbit == 3'h7 && fw == FW_DATA &&
                    !fw_rd && fw_dir_ok;
  // Link clock stops between frames, so the latch clears frame state
  always_ff @(posedge serial_port_clock or posedge transaction_latch) begin
    if (transaction_latch) begin
      fw <= FW_ADDR;
      fbit <= 3'h0;
      fbcnt <= 3'h0;
      fw_rd <= 1'b0;
      fw_dir_ok <= 1'b0;
      fsh <= 8'h00;
    end else begin
      fsh <= fsh_next;
      fbit <= fbit + 3'h1;
      if (fbit == 3'h7) begin
        unique case (fw)
          FW_ADDR: begin
            fw_dir_ok <= fsh_next[7:2] == `FW_ADDR_FIXED &&
                         fsh_next[1] == fw_alo_s[1];
            fw_rd <= fsh_next[0];
            fw <= (fsh_next[7:2] == `FW_ADDR_FIXED) ? FW_SUB : FW_SKIP;
            fbcnt <= 3'h0;
          end
          FW_SUB: begin
            if (fbcnt == 3'h0) begin
              fsub[11:8] <= fsh_next[3:0];
              fbcnt <= 3'h1;
            end else begin
              fsub[7:0] <= fsh_next;
              fbcnt <= 3'h0;
              fw <= FW_DATA;
            end
          end
          FW_DATA: begin
            fdata <= fsh_next;
            fwaddr <= fsub;
            fbcnt <= (fbcnt == word_len(fsub)) ? 3'h0 : fbcnt + 3'h1;
            if (fbcnt == word_len(fsub) && fsub != SUB_TOP)
              fsub <= fsub + 12'h001;
          end
          default: fw <= FW_SKIP;
        endcase
      end
    end
  end
  // Toggle keeps its value across frames; only a full reset clears it
  always_ff @(posedge serial_port_clock or posedge rst) begin
    if (rst)
      fw_tog <= 1'b0;
    else if (fw_wr_byte)
      fw_tog <= ~fw_tog;
  end
  // Read data held while the frame runs; core read is assumed settled
  logic [7:0] fout_sh;
  logic fout_en;
  always_ff @(negedge serial_port_clock or posedge transaction_latch) begin
    if (transaction_latch) begin
      fout_en <= 1'b0;
      fout_sh <= 8'h00;
    end else if (fw == FW_DATA && fw_rd && fw_dir_ok) begin
      fout_en <= 1'b1;
      fout_sh <= (fbit == 3'h0) ? mem_rdata : {fout_sh[6:0], 1'b0};
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_output_line <= 1'b0;
      serial_output_oe_n <= 1'b1;
    end else begin
      serial_output_line <= fout_sh[7];
      serial_output_oe_n <= !(four_wire_mode && fout_en);
    end
  end

  // ------------------------------------------------------------
  // Crossing and core request
  // ------------------------------------------------------------
  logic [2:0] tog_s;
  always_ff @(posedge mclk) begin
    tog_s <= {tog_s[1:0], fw_tog};
  end
  wire fw_ev = tog_s[2] ^ tog_s[1];
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_req <= '0;
      mem_req_valid <= 1'b0;
    end else begin
      mem_req_valid <= tw_req || (fw_ev && four_wire_mode);
      if (tw_req)
        mem_req <= '{addr: sub, data: sh, write: 1'b1};
      else if (fw_ev)
        mem_req <= '{addr: fwaddr, data: fdata, write: 1'b1};
      else
        mem_req.addr <= four_wire_mode ? fsub : sub;
    end
  end
endmodule // dual_mode_control_port_slave

// File: sim/ctrl_port_asserts.sv
// Checker for the control port slave, bound to its top module.
// Assumes the package is compiled first; all checks run on mclk.
`timescale 1ns/1ps
module ctrl_port_asserts
  import ctrl_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic transaction_latch,
  input wire logic serial_output_oe_n,
  input wire mem_req_t mem_req,
  input wire logic mem_req_valid,
  input wire logic four_wire_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence ack_begins;
    $fell(sda_oe_n);
  endsequence
  chk_ack_holds: assert property (ack_begins |-> !sda_oe_n [*4])
    else $error("slave pull released too early");
  // A change with SCL high would look like a start or stop
  chk_no_bus_start: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("slave moved SDA while SCL high");
  chk_mode_sticky: assert property (four_wire_mode |=> four_wire_mode)
    else $error("four-wire mode dropped");
  chk_pins_quiet: assert property (four_wire_mode |-> sda_oe_n)
    else $error("SDA driven in four-wire mode");
  chk_out_released: assert property ((!four_wire_mode ||
    transaction_latch && $past(transaction_latch, 4)) |-> serial_output_oe_n)
    else $error("serial output driven outside a read");
  chk_valid_pulse: assert property (mem_req_valid |=> !mem_req_valid)
    else $error("request valid longer than one cycle");
  chk_write_acked: assert property (mem_req_valid && mem_req.write &&
    !four_wire_mode |-> ##[0:4] !sda_oe_n)
    else $error("write without acknowledge");
  chk_reset_state: assert property ($past(rst) |-> sda_oe_n &&
    serial_output_oe_n && !mem_req_valid && !four_wire_mode)
    else $error("outputs not at reset values");
endmodule // ctrl_port_asserts

bind dual_mode_control_port_slave ctrl_port_asserts u_chk (.mclk(mclk),
  .rst(rst), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .transaction_latch(transaction_latch),
  .serial_output_oe_n(serial_output_oe_n), .mem_req(mem_req),
  .mem_req_valid(mem_req_valid), .four_wire_mode(four_wire_mode));

// File: sim/ctrl_port_host.sv
// Host model: two-wire bus master and four-wire frame source.
// Assumes the bench joins SDA as a pulled-up wired-and.
`timescale 1ns/1ps
module ctrl_port_host (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel,
  output logic spc,
  output logic sin,
  output logic latch
);
  initial begin
    scl = 1;
    sda_rel = 1;
    spc = 0;
    sin = 0;
    latch = 1;
  end
  // Slow quarter bit, far beyond the synchroniser lag
  task automatic q;
    repeat (16) @(negedge mclk);
  endtask
  // SDA moves only in a settled SCL phase: no false start or stop
  task automatic start;
    sda_rel = 1;
    q();
    scl = 1;
    q();
    sda_rel = 0;
    q();
    scl = 0;
    q();
  endtask
  task automatic stop;
    sda_rel = 0;
    q();
    scl = 1;
    q();
    sda_rel = 1;
    q();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    sda_rel = b;
    q();
    scl = 1;
    q();
    q();
    r = sda;
    scl = 0;
    q();
  endtask
  // Byte MSB first, then the ninth bit; all ones reads
  task automatic xfer(input logic [7:0] tx, input logic nine,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(nine, ack);
  endtask
  task automatic pulses;
    repeat (3) begin
      #100 latch = 0;
      #100 latch = 1;
    end
    #100;
  endtask
  // Link clock runs only inside a frame
  task automatic frame(input logic [31:0] w);
    #13 latch = 0;
    for (int i = 31; i >= 0; i--) begin
      #20 sin = w[i];
      #20 spc = 1;
      #40 spc = 0;
    end
    #40 latch = 1;
    sin = ~sin;
  endtask
endmodule // ctrl_port_host

// File: sim/dual_mode_control_port_slave_tb.sv
// Self-checking bench for the control port slave.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
module dual_mode_control_port_slave_tb;
  import ctrl_port_pkg::*;
  logic mclk = 0;
  logic rst;
  logic lo = 0;
  logic hi = 0;
  logic [7:0] mem_rdata = 8'h00;
  logic scl, sda_rel, spc, sin, latch, sda_out, sda_oe_n, sol, sol_oe_n;
  logic vld, fw;
  logic [7:0] ak;
  logic [7:0] rx [4];
  logic [31:0] lfsr = 32'h489E;
  mem_req_t req;
  mem_req_t got[$];
  int mismatches = 0;
  int num_checks = 0;
  wire sda = sda_rel & sda_oe_n;
  always #4 mclk = ~mclk;
  dual_mode_control_port_slave dut (.mclk(mclk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .serial_port_clock(spc), .serial_input_line(sin),
    .transaction_latch(latch), .serial_output_line(sol),
    .serial_output_oe_n(sol_oe_n), .addr_select_lo_pin(lo),
    .addr_select_hi_pin(hi), .mem_req(req), .mem_req_valid(vld),
    .mem_rdata(mem_rdata), .four_wire_mode(fw));
  ctrl_port_host h (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel),
    .spc(spc), .sin(sin), .latch(latch));
  function automatic logic [7:0] rd_val(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'hA};
  endfunction
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(negedge mclk) mem_rdata <= rd_val(req.addr);
  always @(posedge mclk) if (vld === 1'b1 && req.write === 1'b1) got.push_back(req);
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bounded wait: a lost write must not hang the run
  task automatic want(input mem_req_t e);
    for (int t = 0; t < 400 && got.size() == 0; t++) @(negedge mclk);
    if (got.size() == 0) begin
      mismatches++;
      $display("[FAIL] mem write expected %h seen none", e);
      summarize();
    end
    chk("mem write", e, got.pop_front());
  endtask
  task automatic access(input logic [7:0] a, input logic [11:0] s,
                        input logic rd, input int n, input logic [7:0] wd);
    h.start();
    h.xfer(a, 1'b1, rx[3], ak[0]);
    h.xfer({4'h0, s[11:8]}, 1'b1, rx[3], ak[1]);
    h.xfer(s[7:0], 1'b1, rx[3], ak[2]);
    if (rd) begin
      h.start();
      h.xfer(a | 8'h01, 1'b1, rx[3], ak[3]);
    end
    for (int i = 0; i < n; i++)
      h.xfer(rd ? 8'hFF : wd + i[7:0], rd ? i == n - 1 : 1'b1, rx[i], ak[4 + i]);
    h.stop();
  endtask
  initial begin
    logic [7:0] a;
    logic [11:0] s;
    logic [7:0] d;
    rst = 1;
    repeat (8) @(negedge mclk);
    rst = 0;
    repeat (4) @(negedge mclk);
    for (int k = 0; k < 4; k++) begin
      lfsr = step(lfsr);
      {hi, lo} = k[1:0];
      s = {1'b0, lfsr[10:0]};
      d = lfsr[23:16];
      a = {5'b01101, hi, lo, 1'b0};
      repeat (8) @(negedge mclk);
      access(a, s, 0, 2, d);
      chk("write acks", 0, {ak[5:4], ak[2:0]});
      want({s, d, 1'b1});
      want({s + 12'h1, d + 8'h1, 1'b1});
      access(a, s, 1, 2, d);
      chk("read acks", 0, ak[3:0]);
      chk("read bytes", {rd_val(s), rd_val(s + 12'h1)}, {rx[0], rx[1]});
      access(a ^ 8'h20, s, 0, 1, d);
      chk("foreign address ack", 1, ak[0]);
    end
    access(a, 12'hFFF, 0, 2, d);
    chk("write past top acks", 2, ak[5:4]);
    want({12'hFFF, d, 1'b1});
    access(a, 12'hFFE, 1, 3, d);
    chk("read past top", {rd_val(12'hFFE), {2{rd_val(12'hFFF)}}},
        {rx[0], rx[1], rx[2]});
    h.pulses();
    chk("four wire mode", 1, fw);
    h.frame({6'h00, lo, 1'b0, 4'h0, s, d});
    want({s, d, 1'b1});
    access(a, s, 0, 1, d);
    chk("mode held, bus quiet", 3, {fw, ak[0]});
    chk("stray writes", 0, got.size());
    summarize();
  end
endmodule // dual_mode_control_port_slave_tb
